// ===== hw/bsx_exec.sv
// execute stage for bit clear/set/test, increment-skip and inclusive or
`timescale 1ns/1ps
`default_nettype none
module bsx_exec #(
    parameter int unsigned PORT_W = 8
) (
    input  wire logic                      ref_clk,
    input  wire logic                      reset_n,
    input  wire bsx_pkg::bsx_fetch_t       fetch,
    input  wire logic [bsx_pkg::DATA_W-1:0] file_rdata,
    input  wire logic [PORT_W-1:0]         port_a_pins,
    input  wire logic [PORT_W-1:0]         port_b_pins,
    input  wire logic                      pre_to_timer,
    output logic [bsx_pkg::ADDR_W-1:0]     file_raddr,
    output bsx_pkg::bsx_fwr_t              file_wr,
    output logic [bsx_pkg::DATA_W-1:0]     work_reg,
    output logic                           zero_flag,
    output logic                           skip_flush,
    output logic                           exec_busy,
    output logic                           prescale_clr,
    output logic                           insn_done
);
    bsx_pkg::bsx_state_t st_q;
    bsx_pkg::bsx_state_t st_d;
    logic [PORT_W-1:0] pa_s1_q, pa_s2_q, pa_s3_q, pa_st_q;
    logic [PORT_W-1:0] pb_s1_q, pb_s2_q, pb_s3_q, pb_st_q;

    // filtered pin level: change counts once stage 2 and 3 agree
    function automatic logic [PORT_W-1:0] pin_filt(
        input logic [PORT_W-1:0] s2,
        input logic [PORT_W-1:0] s3,
        input logic [PORT_W-1:0] old
    );
        pin_filt = (s2 == s3) ? s3 : old;
    endfunction

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pa_s1_q <= '0;
            pa_s2_q <= '0;
            pa_s3_q <= '0;
            pa_st_q <= '0;
            pb_s1_q <= '0;
            pb_s2_q <= '0;
            pb_s3_q <= '0;
            pb_st_q <= '0;
        end else begin
            pa_s1_q <= port_a_pins;
            pa_s2_q <= pa_s1_q;
            pa_s3_q <= pa_s2_q;
            pa_st_q <= pin_filt(pa_s2_q, pa_s3_q, pa_st_q);
            pb_s1_q <= port_b_pins;
            pb_s2_q <= pb_s1_q;
            pb_s3_q <= pb_s2_q;
            pb_st_q <= pin_filt(pb_s2_q, pb_s3_q, pb_st_q);
        end
    end

    logic [bsx_pkg::INSN_W-1:0] insn;
    logic [bsx_pkg::ADDR_W-1:0] f_addr;
    logic [2:0]                 b_idx;
    logic                       dest_f;
    logic [bsx_pkg::DATA_W-1:0] f_val;
    logic [bsx_pkg::DATA_W-1:0] result;
    logic [bsx_pkg::DATA_W-1:0] mask;
    logic                       is_clr, is_set, is_tst, is_inc, is_or;

    assign insn   = fetch.insn;
    assign f_addr = insn[bsx_pkg::ADDR_W-1:0];
    assign b_idx  = insn[bsx_pkg::BIDX_LO+2:bsx_pkg::BIDX_LO];
    assign dest_f = insn[bsx_pkg::DEST_POS];
    assign mask   = 8'h01 << b_idx;
    assign is_clr = insn[bsx_pkg::OP_HI:bsx_pkg::BITOP_LO]
                    == bsx_pkg::OP_BIT_CLEAR;
    assign is_set = insn[bsx_pkg::OP_HI:bsx_pkg::BITOP_LO]
                    == bsx_pkg::OP_BIT_SET;
    assign is_tst = insn[bsx_pkg::OP_HI:bsx_pkg::BITOP_LO]
                    == bsx_pkg::OP_TEST_CLR;
    assign is_inc = insn[bsx_pkg::OP_HI:bsx_pkg::BYTOP_LO]
                    == bsx_pkg::OP_INC_SKIP;
    assign is_or  = insn[bsx_pkg::OP_HI:bsx_pkg::BYTOP_LO]
                    == bsx_pkg::OP_OR_WORK;

    always_comb begin
        if (PORT_W >= bsx_pkg::DATA_W && f_addr == bsx_pkg::ADDR_PORT_A)
            f_val = pa_st_q[bsx_pkg::DATA_W-1:0];
        else if (PORT_W >= bsx_pkg::DATA_W
                 && f_addr == bsx_pkg::ADDR_PORT_B)
            f_val = pb_st_q[bsx_pkg::DATA_W-1:0];
        else
            f_val = file_rdata;
    end

    // left combinational: the file answers within the same cycle, and a
    // register here would cost every instruction an extra cycle
    assign file_raddr = f_addr;

    always_comb begin
        st_d        = st_q;
        st_d.fwr.we = 1'b0;
        st_d.pre_clr = 1'b0;
        st_d.done   = 1'b0;
        st_d.skip   = 1'b0;
        st_d.busy   = 1'b0;
        result      = f_val;
        unique case (st_q.phase)
            bsx_pkg::BSX_EXEC: begin
                if (fetch.valid) begin
                    st_d.done = 1'b1;
                    st_d.fwr.addr = f_addr;
                    if (is_clr) begin
                        result = f_val & ~mask;
                        st_d.fwr.we = 1'b1;
                    end else if (is_set) begin
                        result = f_val | mask;
                        st_d.fwr.we = 1'b1;
                    end else if (is_tst) begin
                        st_d.skip = ~|(f_val & mask);
                    end else if (is_inc) begin
                        result = f_val + 8'h01;
                        st_d.skip = (result == 8'h00);
                        st_d.fwr.we = dest_f;
                        if (!dest_f)
                            st_d.work = result;
                    end else if (is_or) begin
                        result = st_q.work | f_val;
                        st_d.zero = (result == 8'h00);
                        st_d.fwr.we = dest_f;
                        if (!dest_f)
                            st_d.work = result;
                    end else begin
                        st_d.done = 1'b0;
                    end
                    st_d.fwr.data = result;
                    st_d.pre_clr = st_d.fwr.we && pre_to_timer
                                   && f_addr == bsx_pkg::ADDR_TIMER_ZERO;
                    if (st_d.skip) begin
                        st_d.phase = bsx_pkg::BSX_NOP_SLOT;
                        st_d.busy  = 1'b1;
                    end
                end
            end
            bsx_pkg::BSX_NOP_SLOT: begin
                st_d.phase = bsx_pkg::BSX_EXEC;
            end
            default: st_d.phase = bsx_pkg::BSX_EXEC;
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q.phase   <= bsx_pkg::BSX_EXEC;
            st_q.fwr     <= '0;
            st_q.work    <= bsx_pkg::WORK_RESET;
            st_q.zero    <= bsx_pkg::ZERO_RESET;
            st_q.skip    <= 1'b0;
            st_q.busy    <= 1'b0;
            st_q.pre_clr <= 1'b0;
            st_q.done    <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    assign file_wr      = st_q.fwr;
    assign work_reg     = st_q.work;
    assign zero_flag    = st_q.zero;
    assign skip_flush   = st_q.skip;
    assign exec_busy    = st_q.busy;
    assign prescale_clr = st_q.pre_clr;
    assign insn_done    = st_q.done;

    // assertion helpers: previous decode
    logic [bsx_pkg::DATA_W-1:0] p_fval, p_mask, p_work;
    logic p_v, p_clr, p_set, p_tst, p_inc, p_or, p_dest, p_ex;
    logic [bsx_pkg::ADDR_W-1:0] p_addr;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            {p_v, p_clr, p_set, p_tst, p_inc, p_or, p_dest, p_ex} <= '0;
            p_fval <= '0;
            p_mask <= '0;
            p_work <= '0;
            p_addr <= '0;
        end else begin
            p_v    <= fetch.valid;
            p_ex   <= st_q.phase == bsx_pkg::BSX_EXEC;
            p_clr  <= is_clr;
            p_set  <= is_set;
            p_tst  <= is_tst;
            p_inc  <= is_inc;
            p_or   <= is_or;
            p_dest <= dest_f;
            p_fval <= f_val;
            p_mask <= mask;
            p_work <= st_q.work;
            p_addr <= f_addr;
        end
    end
    logic p_go;
    assign p_go = p_v && p_ex;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    sequence s_skip_pulse;
        skip_flush && exec_busy;
    endsequence
    // slot after a skip: no write, no new skip, nothing retired
    sequence s_nop_slot;
        !file_wr.we && !skip_flush && !insn_done;
    endsequence
    sequence s_skip_taken;
        s_skip_pulse ##1 s_nop_slot;
    endsequence

    chk_clear_bit_value: assert property (
        p_go && p_clr |-> file_wr.we && file_wr.data == (p_fval & ~p_mask)
        && zero_flag == $past(zero_flag))
        else $error("bit clear wrong");
    chk_set_bit_value: assert property (
        p_go && p_set |-> file_wr.we && file_wr.data == (p_fval | p_mask))
        else $error("bit set wrong");
    chk_test_skip_clear: assert property (
        p_go && p_tst |-> skip_flush == ((p_fval & p_mask) == 8'h00)
        && !file_wr.we)
        else $error("bit test skip wrong");
    chk_skip_nop_slot: assert property (
        skip_flush |-> exec_busy ##1 s_nop_slot)
        else $error("skip slot not a nop");
    chk_two_cycle_skip: assert property (
        $rose(skip_flush) |-> ##1 !insn_done)
        else $error("skip not two cycles");
    chk_inc_result: assert property (
        p_go && p_inc |-> file_wr.data == p_fval + 8'h01
        && zero_flag == $past(zero_flag))
        else $error("increment wrong");
    chk_inc_zero_skip: assert property (
        p_go && p_inc && p_fval == 8'hff |-> s_skip_taken)
        else $error("increment zero no skip");
    chk_or_dest_work: assert property (
        p_go && (p_or || p_inc) && !p_dest |-> !file_wr.we
        && work_reg == file_wr.data)
        else $error("destination work wrong");
    chk_or_zero_flag: assert property (
        p_go && p_or |-> zero_flag == ((p_work | p_fval) == 8'h00))
        else $error("or zero flag wrong");
    chk_timer_prescale: assert property (
        file_wr.we && file_wr.addr == bsx_pkg::ADDR_TIMER_ZERO
        && $past(pre_to_timer) |-> prescale_clr)
        else $error("prescaler not cleared");
    chk_prescale_cause: assert property (
        prescale_clr |-> file_wr.we
        && file_wr.addr == bsx_pkg::ADDR_TIMER_ZERO && $past(pre_to_timer))
        else $error("prescaler cleared without timer write");
    chk_inc_no_skip: assert property (
        p_go && p_inc && p_fval != 8'hff |-> !skip_flush && insn_done)
        else $error("increment skipped on nonzero result");
    chk_or_result_data: assert property (
        p_go && p_or |-> file_wr.data == (p_work | p_fval)
        && file_wr.we == p_dest && !skip_flush)
        else $error("or result wrong");
    chk_dest_file_write: assert property (
        p_go && (p_or || p_inc) && p_dest |-> file_wr.we
        && file_wr.addr == p_addr && work_reg == p_work)
        else $error("destination file wrong");
    chk_set_test_flags: assert property (
        p_go && (p_set || p_tst) |-> zero_flag == $past(zero_flag))
        else $error("bit op changed zero flag");
    chk_port_a_read: assert property (
        p_go && p_addr == bsx_pkg::ADDR_PORT_A
        |-> p_fval == $past(pa_st_q[bsx_pkg::DATA_W-1:0]))
        else $error("port a read did not use pins");
    chk_port_b_read: assert property (
        p_go && p_addr == bsx_pkg::ADDR_PORT_B
        |-> p_fval == $past(pb_st_q[bsx_pkg::DATA_W-1:0]))
        else $error("port b read did not use pins");
endmodule : bsx_exec
`default_nettype wire

// ===== hw/bsx_pkg.sv
// shared types and constants for the bit/skip/or execute block
package bsx_pkg;
    localparam int unsigned INSN_W   = 14;
    localparam int unsigned ADDR_W   = 7;
    localparam int unsigned DATA_W   = 8;
    // opcode field positions
    localparam int unsigned OP_HI    = 13;
    localparam int unsigned BITOP_LO = 10;
    localparam int unsigned BYTOP_LO = 8;
    localparam int unsigned DEST_POS = 7;
    localparam int unsigned BIDX_LO  = 7;
    // top opcode patterns
    localparam logic [3:0] OP_BIT_CLEAR = 4'h4;  // 01 00
    localparam logic [3:0] OP_BIT_SET   = 4'h5;  // 01 01
    localparam logic [3:0] OP_TEST_CLR  = 4'h6;  // 01 10
    localparam logic [5:0] OP_INC_SKIP  = 6'h0f; // 00 1111
    localparam logic [5:0] OP_OR_WORK   = 6'h04; // 00 0100
    // special file addresses and reset values
    localparam logic [6:0] ADDR_TIMER_ZERO = 7'h01;
    localparam logic [6:0] ADDR_PORT_A     = 7'h05;
    localparam logic [6:0] ADDR_PORT_B     = 7'h06;
    localparam logic [7:0] WORK_RESET      = 8'h00;
    localparam logic       ZERO_RESET      = 1'b0;

    typedef enum logic [1:0] {
        BSX_EXEC    = 2'b01,
        BSX_NOP_SLOT = 2'b10
    } bsx_phase_t;

    // request from fetch stage
    typedef struct packed {
        logic              valid;
        logic [INSN_W-1:0] insn;
    } bsx_fetch_t;

    // write port to the register file
    typedef struct packed {
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } bsx_fwr_t;

    // execute phase and registered outputs (pin filters held apart)
    typedef struct packed {
        bsx_phase_t        phase;
        bsx_fwr_t          fwr;
        logic [DATA_W-1:0] work;
        logic              zero;
        logic              skip;
        logic              busy;
        logic              pre_clr;
        logic              done;
    } bsx_state_t;
endpackage : bsx_pkg

// ===== tb/bsx_tb.sv
// self-checking bench for the bit/skip/or execute block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
        n_errors++; \
        $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); \
    end \
end
module testbench;
    logic                ref_clk      = 1'b0;
    logic                reset_n      = 1'b0;
    bsx_pkg::bsx_fetch_t fetch        = '0;
    logic [7:0]          file_rdata   = 8'h00;
    logic [7:0]          port_a_pins  = 8'h00;
    logic [7:0]          port_b_pins  = 8'h0f;
    logic                pre_to_timer = 1'b0;
    logic [6:0]          file_raddr;
    bsx_pkg::bsx_fwr_t   file_wr;
    logic [7:0]          work_reg;
    logic                zero_flag;
    logic                skip_flush;
    logic                exec_busy;
    logic                prescale_clr;
    logic                insn_done;
    int                  n_errors     = 0;
    int                  tests_run    = 0;

    always #2.5 ref_clk = ~ref_clk;

    bsx_exec u_dut (
        .ref_clk      (ref_clk),
        .reset_n      (reset_n),
        .fetch        (fetch),
        .file_rdata   (file_rdata),
        .port_a_pins  (port_a_pins),
        .port_b_pins  (port_b_pins),
        .pre_to_timer (pre_to_timer),
        .file_raddr   (file_raddr),
        .file_wr      (file_wr),
        .work_reg     (work_reg),
        .zero_flag    (zero_flag),
        .skip_flush   (skip_flush),
        .exec_busy    (exec_busy),
        .prescale_clr (prescale_clr),
        .insn_done    (insn_done)
    );

    function automatic logic [13:0] bit_op(input logic [3:0] op,
        input logic [2:0] b, input logic [6:0] f);
        return {op, b, f};
    endfunction

    function automatic logic [13:0] byte_op(input logic [5:0] op,
        input logic d, input logic [6:0] f);
        return {op, d, f};
    endfunction

    task automatic drive(input logic v, input logic [13:0] insn,
        input logic [7:0] rd);
        @(posedge ref_clk);
        fetch <= '{valid: v, insn: insn};
        file_rdata <= rd;
    endtask

    // one instruction, then idle; answer is looked at in its only cycle
    task automatic run_op(input logic [13:0] insn, input logic [7:0] rd);
        drive(1'b1, insn, rd);
        drive(1'b0, 14'h0000, 8'h00);
        #1;
    endtask

    task automatic chk_wr(input logic we, input logic [6:0] a,
        input logic [7:0] d, input logic sk);
        `CHK("write enable", we, file_wr.we)
        if (we) begin
            `CHK("write address", a, file_wr.addr)
            `CHK("write data", d, file_wr.data)
        end
        `CHK("skip flush", sk, skip_flush)
        `CHK("exec busy", sk, exec_busy)
        `CHK("insn done", 1'b1, insn_done)
    endtask

    task automatic t_or_file;
        run_op(byte_op(bsx_pkg::OP_OR_WORK, 1'b1, 7'h22), 8'h00);
        chk_wr(1'b1, 7'h22, 8'h00, 1'b0);
        `CHK("zero flag", 1'b1, zero_flag)
        `CHK("work reg", 8'h00, work_reg)
    endtask

    task automatic t_bits;
        drive(1'b1, bit_op(bsx_pkg::OP_BIT_CLEAR, 3'd7, 7'h20), 8'hc7);
        #1;
        `CHK("read address", 7'h20, file_raddr)
        drive(1'b0, 14'h0000, 8'h00);
        #1;
        chk_wr(1'b1, 7'h20, 8'h47, 1'b0);
        for (int b = 0; b < 8; b++) begin
            run_op(bit_op(bsx_pkg::OP_BIT_SET, 3'(b), 7'h7f), 8'h00);
            chk_wr(1'b1, 7'h7f, 8'h01 << b, 1'b0);
            run_op(bit_op(bsx_pkg::OP_BIT_CLEAR, 3'(b), 7'h00), 8'hff);
            chk_wr(1'b1, 7'h00, ~(8'h01 << b), 1'b0);
        end
        `CHK("zero flag", 1'b1, zero_flag)
    endtask

    task automatic t_skip;
        drive(1'b1, bit_op(bsx_pkg::OP_TEST_CLR, 3'd2, 7'h24), 8'hfb);
        // prefetched word offered while the skip is resolved
        drive(1'b1, bit_op(bsx_pkg::OP_BIT_SET, 3'd0, 7'h25), 8'h00);
        #1;
        chk_wr(1'b0, 7'h00, 8'h00, 1'b1);
        drive(1'b0, 14'h0000, 8'h00);
        #1;
        `CHK("slot write", 1'b0, file_wr.we)
        `CHK("slot done", 1'b0, insn_done)
        run_op(bit_op(bsx_pkg::OP_TEST_CLR, 3'd2, 7'h24), 8'h04);
        chk_wr(1'b0, 7'h00, 8'h00, 1'b0);
        `CHK("zero flag", 1'b1, zero_flag)
    endtask

    task automatic t_inc;
        run_op(byte_op(bsx_pkg::OP_INC_SKIP, 1'b1, 7'h30), 8'hff);
        chk_wr(1'b1, 7'h30, 8'h00, 1'b1);
        @(posedge ref_clk);
        #1;
        `CHK("slot done", 1'b0, insn_done)
        run_op(byte_op(bsx_pkg::OP_INC_SKIP, 1'b0, 7'h31), 8'h05);
        chk_wr(1'b0, 7'h00, 8'h00, 1'b0);
        `CHK("work reg", 8'h06, work_reg)
        `CHK("zero flag", 1'b1, zero_flag)
    endtask

    task automatic t_or_work;
        run_op(byte_op(bsx_pkg::OP_OR_WORK, 1'b0, 7'h21), 8'h13);
        chk_wr(1'b0, 7'h00, 8'h00, 1'b0);
        `CHK("work reg", 8'h17, work_reg)
        `CHK("zero flag", 1'b0, zero_flag)
        run_op(byte_op(bsx_pkg::OP_OR_WORK, 1'b1, 7'h23), 8'h80);
        chk_wr(1'b1, 7'h23, 8'h97, 1'b0);
        `CHK("work kept", 8'h17, work_reg)
    endtask

    task automatic t_timer;
        @(posedge ref_clk);
        pre_to_timer <= 1'b1;
        run_op(bit_op(bsx_pkg::OP_BIT_SET, 3'd0, 7'h01), 8'h10);
        `CHK("prescale clr", 1'b1, prescale_clr)
        run_op(byte_op(bsx_pkg::OP_OR_WORK, 1'b0, 7'h01), 8'h10);
        `CHK("no clr d0", 1'b0, prescale_clr)
        run_op(byte_op(bsx_pkg::OP_OR_WORK, 1'b1, 7'h01), 8'h10);
        `CHK("clr on d1", 1'b1, prescale_clr)
        run_op(bit_op(bsx_pkg::OP_BIT_SET, 3'd0, 7'h02), 8'h10);
        `CHK("no clr other", 1'b0, prescale_clr)
        @(posedge ref_clk);
        pre_to_timer <= 1'b0;
        run_op(bit_op(bsx_pkg::OP_BIT_SET, 3'd0, 7'h01), 8'h10);
        `CHK("no clr wdt", 1'b0, prescale_clr)
    endtask

    // pins differ from the latch value offered on the read bus
    task automatic t_ports;
        run_op(bit_op(bsx_pkg::OP_BIT_SET, 3'd0, 7'h05), 8'hff);
        chk_wr(1'b1, 7'h05, 8'h01, 1'b0);
        run_op(bit_op(bsx_pkg::OP_BIT_CLEAR, 3'd7, 7'h06), 8'hf0);
        chk_wr(1'b1, 7'h06, 8'h0f, 1'b0);
    endtask

    task automatic test_done;
        if (n_errors == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        // let the pin filters settle before any port access
        repeat (6) @(posedge ref_clk);
        t_or_file();
        t_bits();
        t_skip();
        t_inc();
        t_or_work();
        t_timer();
        t_ports();
        test_done();
    end

    // whole run is under a hundred cycles; this is far beyond it
    initial begin
        #20000;
        n_errors++;
        test_done();
    end
endmodule // testbench
`default_nettype wire
